// >>> rtl/dsrp_sequencer.sv
// power-state sequencer of a serial flash: wake/signature command and power-up gating
//
// Behaviour
// - the wake command returns an 8-bit legacy signature, not the 16-bit one.
// - with no internal cycle running, wake command answers even outside deep sleep.
// - wake command during a running cycle is not decoded, cycle unaffected.
// - select low, command byte, three dummy bytes, input sampled on rising clock.
// - after the dummy bytes the signature shifts out on falling clock edges.
// - continued clocking with select low repeats the signature endlessly.
// - select rising after the signature puts the device into standby.
// - standby is immediate if awake, else after the long wake time.
// - select rising before a full signature still wakes, after short wake time.
// - while power-on reset is active, no operation and no command response.
// - write-type commands ignored until the write-inhibit delay after reset.
// - read commands accepted once the select-after-power-up delay has passed.
// - after reset: standby, write latch clear, cycle flag clear.
// - reasserted power-on reset disables everything at power-down.
// - delivered state: array bytes FFh, status register 00h.
// - deep sleep ignores writes and is entered only by deep-sleep command.
`timescale 1ns/100ps
module dsrp_sequencer #(
  parameter logic [7:0] SIGNATURE = dsrp_pkg::LEGACY_SIG_DEFAULT,
  parameter int SHORT_WAKE_CYCLES = dsrp_pkg::SHORT_WAKE_CYC,
  parameter int LONG_WAKE_CYCLES = dsrp_pkg::LONG_WAKE_CYC,
  parameter int SELECT_DELAY_CYCLES = dsrp_pkg::SELECT_DELAY_CYC,
  parameter int WRITE_INHIBIT_CYCLES = dsrp_pkg::WRITE_INHIBIT_CYC
) (
  // clock and power-on reset
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  // serial pins
  input wire logic SEL_N_IN,
  input wire logic SCLK_IN,
  input wire logic SDI_IN,
  output logic SDO_OUT,
  output logic SDO_OE_OUT,
  // array side
  input wire logic CYCLE_BUSY_IN,
  input wire logic LATCH_CLEAR_IN,
  output logic CMD_VALID_OUT,
  output logic [7:0] CMD_OPCODE_OUT,
  // power state
  output logic DEEP_SLEEP_OUT,
  output logic STANDBY_OUT,
  output logic SELECT_READY_OUT,
  output logic WRITE_READY_OUT,
  output logic [7:0] STATUS_OUT
);
  localparam int WAKE_W = 16;
  localparam int PU_W = 24;

  typedef enum logic [2:0] {
    ST_STANDBY = 3'b001,
    ST_DEEP = 3'b010,
    ST_WAKING = 3'b100
  } dsrp_state_t;

  dsrp_state_t state_q;
  logic sel_s1_q, sel_s2_q, sel_prev_q;
  logic sclk_s1_q, sclk_s2_q, sclk_prev_q;
  logic sdi_s1_q, sdi_s2_q;
  logic sel_rise, sclk_rise, sclk_fall, opcode_done;
  logic [5:0] rx_cnt_q;
  logic [6:0] rx_shift_q;
  logic [7:0] opcode_d, opcode_q;
  logic opcode_valid_q;
  logic wake_ok_q, cmd_ok_q, sig_read_q;
  logic [2:0] tx_idx_q;
  logic tx_shift;
  logic wake_start, wake_done, wake_long_q;
  logic [WAKE_W-1:0] wake_load;
  logic [WAKE_W-1:0] wake_len_q;
  logic [PU_W-1:0] pu_cnt_q;
  logic select_ok, inhibit_done;
  logic latch_q, busy_q;

  function automatic logic is_write_type(input logic [7:0] op);
    is_write_type = (op == dsrp_pkg::OP_WRITE_LATCH_SET) || (op == dsrp_pkg::OP_PAGE_WRITE) ||
      (op == dsrp_pkg::OP_SECTOR_CLEAR) || (op == dsrp_pkg::OP_WHOLE_CLEAR) ||
      (op == dsrp_pkg::OP_STATUS_WRITE);
  endfunction : is_write_type

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; the serial clock is sampled, not used as a clock
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sel_s1_q <= 1'b1;
      sel_s2_q <= 1'b1;
      sel_prev_q <= 1'b1;
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_prev_q <= 1'b0;
      sdi_s1_q <= 1'b0;
      sdi_s2_q <= 1'b0;
    end else begin
      sel_s1_q <= SEL_N_IN;
      sel_s2_q <= sel_s1_q;
      sel_prev_q <= sel_s2_q;
      sclk_s1_q <= SCLK_IN;
      sclk_s2_q <= sclk_s1_q;
      sclk_prev_q <= sclk_s2_q;
      sdi_s1_q <= SDI_IN;
      sdi_s2_q <= sdi_s1_q;
    end
  end

  assign sel_rise = sel_s2_q & ~sel_prev_q;
  assign sclk_rise = ~sel_s2_q & sclk_s2_q & ~sclk_prev_q;
  assign sclk_fall = ~sel_s2_q & ~sclk_s2_q & sclk_prev_q;
  assign opcode_done = sclk_rise && (rx_cnt_q == dsrp_pkg::CMD_BITS - 6'h01);
  assign opcode_d = {rx_shift_q, sdi_s2_q};

  //////////////////////////////////////////////////////////////////////////////
  // power-up delay counter; reset holds it at zero
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pu_cnt_q <= '0;
    end else if (!inhibit_done || !select_ok) begin
      pu_cnt_q <= pu_cnt_q + {{(PU_W-1){1'b0}}, 1'b1};
    end
  end

  assign select_ok = pu_cnt_q >= PU_W'(SELECT_DELAY_CYCLES);
  assign inhibit_done = pu_cnt_q >= PU_W'(WRITE_INHIBIT_CYCLES);

  //////////////////////////////////////////////////////////////////////////////
  // receive side: bit counter saturates where the signature starts
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rx_cnt_q <= '0;
      rx_shift_q <= '0;
      opcode_q <= '0;
      opcode_valid_q <= 1'b0;
    end else if (sel_s2_q) begin
      rx_cnt_q <= '0;
      opcode_valid_q <= 1'b0;
    end else if (sclk_rise) begin
      rx_shift_q <= opcode_d[6:0];
      if (rx_cnt_q != dsrp_pkg::SIG_START_BITS) begin
        rx_cnt_q <= rx_cnt_q + 6'h01;
      end
      if (opcode_done) begin
        opcode_q <= opcode_d;
        opcode_valid_q <= 1'b1;
      end
    end
  end

  // command decode; frames during the wake delay are ignored
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      wake_ok_q <= 1'b0;
      cmd_ok_q <= 1'b0;
      CMD_VALID_OUT <= 1'b0;
      CMD_OPCODE_OUT <= 8'h00;
    end else begin
      CMD_VALID_OUT <= 1'b0;
      if (sel_s2_q) begin
        wake_ok_q <= 1'b0;
        cmd_ok_q <= 1'b0;
      end else if (opcode_done && state_q != ST_WAKING) begin
        wake_ok_q <= (opcode_d == dsrp_pkg::OP_WAKE_SIG) && !busy_q;
        if (state_q == ST_STANDBY && select_ok && opcode_d != dsrp_pkg::OP_WAKE_SIG &&
            !(is_write_type(opcode_d) && !inhibit_done)) begin
          cmd_ok_q <= 1'b1;
          if (opcode_d != dsrp_pkg::OP_DEEP_SLEEP) begin
            CMD_VALID_OUT <= 1'b1;
            CMD_OPCODE_OUT <= opcode_d;
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // signature shifter: first bit on the fall after the dummy bytes
  assign tx_shift = sclk_fall && wake_ok_q && (rx_cnt_q == dsrp_pkg::SIG_START_BITS);

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      tx_idx_q <= dsrp_pkg::SIG_TOP_BIT;
      SDO_OUT <= 1'b0;
      SDO_OE_OUT <= 1'b0;
      sig_read_q <= 1'b0;
    end else if (sel_s2_q) begin
      tx_idx_q <= dsrp_pkg::SIG_TOP_BIT;
      SDO_OE_OUT <= 1'b0;
      sig_read_q <= 1'b0;
    end else begin
      if (tx_shift) begin
        SDO_OUT <= SIGNATURE[tx_idx_q];
        SDO_OE_OUT <= 1'b1;
        tx_idx_q <= tx_idx_q - 3'h1; // wraps back to the top bit
      end
      // lowest bit has been sampled by the host: one whole byte read
      if (sclk_rise && SDO_OE_OUT && tx_idx_q == dsrp_pkg::SIG_TOP_BIT) begin
        sig_read_q <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // power state
  assign wake_start = (state_q == ST_DEEP) && sel_rise && wake_ok_q;
  assign wake_load = sig_read_q ? WAKE_W'(LONG_WAKE_CYCLES) : WAKE_W'(SHORT_WAKE_CYCLES);

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_q <= ST_STANDBY;
    end else begin
      unique case (state_q)
        ST_STANDBY: begin
          // a wake command here is immediate: nothing changes
          if (sel_rise && cmd_ok_q && opcode_valid_q && !busy_q &&
              opcode_q == dsrp_pkg::OP_DEEP_SLEEP && rx_cnt_q == dsrp_pkg::CMD_BITS) begin
            state_q <= ST_DEEP;
          end
        end
        ST_DEEP: begin
          if (wake_start) begin
            state_q <= ST_WAKING;
          end
        end
        ST_WAKING: begin
          if (wake_done) begin
            state_q <= ST_STANDBY;
          end
        end
      endcase
    end
  end

  dsrp_timer #(
    .W(WAKE_W)
  ) u_wake_timer (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .start_in(wake_start),
    .load_in(wake_load),
    .done_out(wake_done)
  );

  //////////////////////////////////////////////////////////////////////////////
  // status bits; the latch is set at the end of an accepted latch-set frame
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      latch_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      busy_q <= CYCLE_BUSY_IN;
      if (sel_rise && cmd_ok_q && state_q == ST_STANDBY &&
          opcode_q == dsrp_pkg::OP_WRITE_LATCH_SET && rx_cnt_q == dsrp_pkg::CMD_BITS) begin
        latch_q <= 1'b1; // set wins over a clear in the same cycle
      end else if (LATCH_CLEAR_IN) begin
        latch_q <= 1'b0;
      end
    end
  end

  always_comb begin
    STATUS_OUT = dsrp_pkg::STATUS_DELIVERED;
    STATUS_OUT[dsrp_pkg::STAT_BUSY_POS] = busy_q;
    STATUS_OUT[dsrp_pkg::STAT_LATCH_POS] = latch_q;
  end

  assign DEEP_SLEEP_OUT = state_q != ST_STANDBY;
  assign STANDBY_OUT = state_q == ST_STANDBY;
  assign SELECT_READY_OUT = select_ok;
  assign WRITE_READY_OUT = inhibit_done;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      wake_len_q <= '0;
      wake_long_q <= 1'b0;
    end else if (wake_start) begin
      wake_len_q <= '0;
      wake_long_q <= sig_read_q;
    end else if (state_q == ST_WAKING) begin
      wake_len_q <= wake_len_q + {{(WAKE_W-1){1'b0}}, 1'b1};
    end
  end

  sequence s_deep_wake;
    (state_q == ST_DEEP) && wake_start;
  endsequence

  sequence s_waking;
    state_q == ST_WAKING;
  endsequence

  a_deep_no_cmd: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    CMD_VALID_OUT |-> $past(state_q) == ST_STANDBY)
    else $error("command forwarded outside standby");

  a_write_inhibit: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    CMD_VALID_OUT && is_write_type(CMD_OPCODE_OUT) |-> $past(inhibit_done))
    else $error("write command passed during inhibit delay");

  a_read_select: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    CMD_VALID_OUT |-> $past(select_ok))
    else $error("command passed before select delay");

  a_busy_no_wake: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    opcode_done && busy_q |=> !wake_ok_q)
    else $error("wake command decoded during busy cycle");

  a_sig_shift: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    tx_shift |=> SDO_OUT == SIGNATURE[$past(tx_idx_q)] && SDO_OE_OUT)
    else $error("signature bit out of order");

  a_sig_msb_first: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    tx_shift && !SDO_OE_OUT |=> SDO_OUT == SIGNATURE[7] ##0 tx_idx_q == 3'h6)
    else $error("signature did not start at top bit");

  a_wake_delay: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    s_deep_wake ##0 sig_read_q |=> s_waking [*8])
    else $error("long wake left early");

  a_wake_length: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    s_waking ##0 wake_done |-> wake_len_q == (wake_long_q ? WAKE_W'(LONG_WAKE_CYCLES) :
                                              WAKE_W'(SHORT_WAKE_CYCLES)))
    else $error("wrong wake delay length");

  a_reset_state: assert property (@(posedge REF_CLK_IN)
    $past(RST_IN) && !RST_IN |-> STANDBY_OUT && STATUS_OUT == 8'h00 && !CMD_VALID_OUT)
    else $error("wrong state after power-on reset");

  a_standby_wake: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (state_q == ST_STANDBY) && sel_rise && wake_ok_q |=> state_q == ST_STANDBY)
    else $error("wake from standby changed state");
endmodule : dsrp_sequencer

// >>> rtl/dsrp_pkg.sv
// constants for the deep-sleep release and power-up sequencer
package dsrp_pkg;
  // reference clock
  localparam int CLK_PERIOD_NS = 10;

  // command codes seen on the serial input
  localparam logic [7:0] OP_WAKE_SIG = 8'hAB;
  localparam logic [7:0] OP_DEEP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
  localparam logic [7:0] OP_SECTOR_CLEAR = 8'hD8;
  localparam logic [7:0] OP_WHOLE_CLEAR = 8'hC7;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;

  // legacy signature byte; value is arbitrary
  localparam logic [7:0] LEGACY_SIG_DEFAULT = 8'h5A;

  // frame layout in serial clock rising edges
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] SIG_START_BITS = 6'h20;
  localparam logic [2:0] SIG_TOP_BIT = 3'h7;

  // status layout and as-delivered values
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_LATCH_POS = 1;
  localparam logic [7:0] STATUS_DELIVERED = 8'h00;
  localparam logic [7:0] ARRAY_ERASED_BYTE = 8'hFF;

  // times in physical units, then cycle counts
  localparam int SHORT_WAKE_NS = 3000;
  localparam int LONG_WAKE_NS = 30000;
  localparam int SELECT_DELAY_US = 10;
  localparam int WRITE_INHIBIT_MS = 10;
  // longest delays round down, least delays round up
  localparam int SHORT_WAKE_CYC = SHORT_WAKE_NS / CLK_PERIOD_NS;
  localparam int LONG_WAKE_CYC = LONG_WAKE_NS / CLK_PERIOD_NS;
  localparam int SELECT_DELAY_CYC = (SELECT_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_INHIBIT_CYC = WRITE_INHIBIT_MS * 1000000 / CLK_PERIOD_NS;
endpackage : dsrp_pkg

// >>> rtl/dsrp_timer.sv
// one-shot down counter used for the wake delays
`timescale 1ns/100ps
module dsrp_timer #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // control
  input wire logic start_in,
  input wire logic [W-1:0] load_in,
  // status
  output logic done_out
);
  logic [W-1:0] cnt_q;
  logic run_q;

  // done pulses once, load cycles after the start pulse
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        cnt_q <= load_in;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
          run_q <= 1'b0;
          done_out <= 1'b1;
        end
        cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule : dsrp_timer

// >>> test/dsrp_host_model.sv
// host serial controller model: drives select, clock and data in, samples data out
`timescale 1ns/100ps
module dsrp_host_model (
  // bench control
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [7:0] op_in,
  input wire logic [6:0] rises_in,
  // serial pins
  input wire logic sdo_in,
  input wire logic sdo_oe_in,
  output logic sel_n_out,
  output logic sclk_out,
  output logic sdi_out,
  // result
  output logic [15:0] rx_out,
  output logic done_out
);
  initial begin
    sel_n_out = 1'b1;
    sclk_out = 1'b0;
    sdi_out = 1'b0;
    rx_out = 16'h0000;
    done_out = 1'b1;
  end
  // clock stands low between frames; an undriven data out reads as pulled high
  always @(posedge clk_in) begin
    if (go_in) begin
      done_out = 1'b0;
      #3.3 sel_n_out = 1'b0;
      for (int i = 0; i < rises_in; i++) begin
        sdi_out = (i < 8) ? op_in[7 - i] : ~sdi_out;
        #31.2 sclk_out = 1'b1;
        rx_out = {rx_out[14:0], sdo_oe_in ? sdo_in : 1'b1};
        #62.5 sclk_out = 1'b0;
        #31.3;
      end
      #62.5 sel_n_out = 1'b1;
      #62.5 done_out = 1'b1;
    end
  end
endmodule : dsrp_host_model

// >>> test/dsrp_sequencer_bench.sv
// self-checking bench of the deep-sleep release and power-up sequencer
`timescale 1ns/100ps
module dsrp_sequencer_bench;
  // short counts keep the run brief
  localparam int SHORT_W = 20;
  localparam int LONG_W = 60;
  localparam int SEL_D = 50;
  localparam int WR_D = 800;
  localparam logic [7:0] SIG = 8'h3C;
  localparam logic [7:0] RD_CODE = 8'h03;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic busy = 1'b0;
  logic wclr = 1'b0;
  logic go = 1'b0;
  logic [7:0] op = 8'h00;
  logic [6:0] rises = 7'h00;
  logic sel_n, sclk, sdi, sdo, sdo_oe, cmd_v, deep, stby, sel_rdy, wr_rdy, hdone;
  logic [7:0] cmd_op, status;
  logic [15:0] rx;
  logic [7:0] wcodes [5];
  int fails = 0;
  int num_checks = 0;
  int ncmd = 0;
  int k, n;

  dsrp_sequencer #(.SIGNATURE(SIG), .SHORT_WAKE_CYCLES(SHORT_W), .LONG_WAKE_CYCLES(LONG_W),
    .SELECT_DELAY_CYCLES(SEL_D), .WRITE_INHIBIT_CYCLES(WR_D)) i_dut (
    .REF_CLK_IN(clk), .RST_IN(rst), .SEL_N_IN(sel_n), .SCLK_IN(sclk), .SDI_IN(sdi),
    .SDO_OUT(sdo), .SDO_OE_OUT(sdo_oe), .CYCLE_BUSY_IN(busy), .LATCH_CLEAR_IN(wclr),
    .CMD_VALID_OUT(cmd_v), .CMD_OPCODE_OUT(cmd_op), .DEEP_SLEEP_OUT(deep),
    .STANDBY_OUT(stby), .SELECT_READY_OUT(sel_rdy), .WRITE_READY_OUT(wr_rdy),
    .STATUS_OUT(status));
  dsrp_host_model i_host (
    .clk_in(clk), .go_in(go), .op_in(op), .rises_in(rises), .sdo_in(sdo),
    .sdo_oe_in(sdo_oe), .sel_n_out(sel_n), .sclk_out(sclk), .sdi_out(sdi),
    .rx_out(rx), .done_out(hdone));

  always #5 clk = ~clk;
  // count forwarded commands away from the launching edge
  always @(negedge clk) if (cmd_v === 1'b1) ncmd++;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (exp !== got) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk_val

  task automatic chk_flag(input string what, input logic exp, input logic got);
    chk_val(what, {15'h0000, exp}, {15'h0000, got});
  endtask : chk_flag

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  task automatic frame(input logic [7:0] code, input logic [6:0] nr);
    int j;
    j = 0;
    op <= code;
    rises <= nr;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (hdone !== 1'b1 && j < 2000) begin
      @(posedge clk);
      j++;
    end
    chk_flag("frame done", 1'b1, hdone);
    repeat (6) @(posedge clk);
  endtask : frame

  task automatic wait_flag(ref logic f, output int cnt);
    cnt = 0;
    while (f !== 1'b1 && cnt < 1000) begin
      @(posedge clk);
      cnt++;
    end
  endtask : wait_flag

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_powerup;
    chk_flag("standby at reset", 1'b1, stby);
    chk_flag("deep at reset", 1'b0, deep);
    chk_val("status at reset", 16'h0000, {8'h00, status});
    chk_flag("select ready in reset", 1'b0, sel_rdy);
    rst <= 1'b0;
    wait_flag(sel_rdy, k);
    chk_flag("select delay", 1'b1, k >= SEL_D - 4 && k <= SEL_D + 4);
    chk_flag("write ready early", 1'b0, wr_rdy);
    for (int i = 0; i < 5; i++) begin
      n = ncmd;
      frame(wcodes[i], 7'h08);
      chk_val("inhibited write", 16'(n), 16'(ncmd));
    end
    frame(RD_CODE, 7'h08);
    chk_val("early read code", {8'h00, RD_CODE}, {8'h00, cmd_op});
    chk_flag("write ready still low", 1'b0, wr_rdy);
    $display("test powerup done");
  endtask : t_powerup

  task automatic t_writes;
    wait_flag(wr_rdy, k);
    for (int i = 0; i < 5; i++) begin
      n = ncmd;
      frame(wcodes[i], 7'h08);
      chk_val("write forwarded", 16'(n + 1), 16'(ncmd));
      chk_val("write code", {8'h00, wcodes[i]}, {8'h00, cmd_op});
    end
    chk_flag("latch set", 1'b1, status[dsrp_pkg::STAT_LATCH_POS]);
    wclr <= 1'b1;
    @(posedge clk);
    wclr <= 1'b0;
    repeat (3) @(posedge clk);
    chk_flag("latch cleared", 1'b0, status[dsrp_pkg::STAT_LATCH_POS]);
    $display("test writes done");
  endtask : t_writes

  task automatic t_wake_awake;
    frame(dsrp_pkg::OP_WAKE_SIG, 7'h30);
    chk_val("repeated signature", {SIG, SIG}, rx);
    chk_flag("standby at once", 1'b1, stby);
    chk_flag("not deep", 1'b0, deep);
    $display("test wake awake done");
  endtask : t_wake_awake

  task automatic t_deep_long;
    frame(dsrp_pkg::OP_DEEP_SLEEP, 7'h08);
    chk_flag("deep entered", 1'b1, deep);
    chk_flag("standby left", 1'b0, stby);
    n = ncmd;
    frame(dsrp_pkg::OP_WRITE_LATCH_SET, 7'h08);
    chk_val("write in deep", 16'(n), 16'(ncmd));
    frame(dsrp_pkg::OP_WAKE_SIG, 7'h28);
    chk_val("signature from deep", {8'h00, SIG}, {8'h00, rx[7:0]});
    chk_flag("still waking", 1'b1, deep);
    wait_flag(stby, k);
    chk_flag("long wake span", 1'b1, k >= LONG_W - 30 && k <= LONG_W);
    chk_flag("deep left", 1'b0, deep);
    $display("test long wake done");
  endtask : t_deep_long

  task automatic t_deep_short;
    frame(dsrp_pkg::OP_DEEP_SLEEP, 7'h08);
    frame(dsrp_pkg::OP_WAKE_SIG, 7'h0C);
    wait_flag(stby, k);
    chk_flag("short wake span", 1'b1, k >= 1 && k <= SHORT_W);
    chk_flag("deep left short", 1'b0, deep);
    $display("test short wake done");
  endtask : t_deep_short

  task automatic t_busy;
    busy <= 1'b1;
    repeat (3) @(posedge clk);
    chk_flag("busy flag", 1'b1, status[dsrp_pkg::STAT_BUSY_POS]);
    frame(dsrp_pkg::OP_WAKE_SIG, 7'h28);
    chk_val("no signature busy", 16'hFFFF, rx);
    frame(dsrp_pkg::OP_DEEP_SLEEP, 7'h08);
    chk_flag("deep refused busy", 1'b0, deep);
    chk_flag("busy kept", 1'b1, status[dsrp_pkg::STAT_BUSY_POS]);
    busy <= 1'b0;
    @(posedge clk);
    $display("test busy done");
  endtask : t_busy

  task automatic t_power_down;
    frame(dsrp_pkg::OP_DEEP_SLEEP, 7'h08);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk_flag("deep dropped", 1'b0, deep);
    chk_flag("standby again", 1'b1, stby);
    chk_flag("ready cleared", 1'b0, sel_rdy | wr_rdy);
    n = ncmd;
    frame(dsrp_pkg::OP_WAKE_SIG, 7'h28);
    chk_val("no answer in reset", 16'hFFFF, rx);
    chk_val("no command in reset", 16'(n), 16'(ncmd));
    rst <= 1'b0;
    wait_flag(sel_rdy, k);
    chk_flag("ready after reset", 1'b1, sel_rdy);
    $display("test power down done");
  endtask : t_power_down

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    wcodes = '{dsrp_pkg::OP_WRITE_LATCH_SET, dsrp_pkg::OP_PAGE_WRITE,
      dsrp_pkg::OP_SECTOR_CLEAR, dsrp_pkg::OP_WHOLE_CLEAR, dsrp_pkg::OP_STATUS_WRITE};
    repeat (6) @(posedge clk);
    t_powerup();
    t_writes();
    t_wake_awake();
    t_deep_long();
    t_deep_short();
    t_busy();
    t_power_down();
    stop_test();
  end

  initial begin
    // nearly three times the cycles that the tests above need
    repeat (12000) @(posedge clk);
    fails++;
    stop_test();
  end
endmodule : dsrp_sequencer_bench
